/* verilog/pse_top.sv */
// Sequencer event logic: Wishbone registers, event matching, sequencer and backplane drive
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module pse_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Event and clock pins
    input  wire logic [7:0]  ev_in,
    input  wire logic [7:0]  lead_ev_in,
    input  wire logic        ext_clk_in,
    // Backplane signals
    input  wire logic [3:0]  bp_sig_in,
    output logic      [3:0]  bp_sig_out,
    output logic      [3:0]  bp_sig_oe,
    // Sequencer outputs
    output logic             pat_inhibit,
    output logic      [3:0]  seq_line,
    output logic             pat_tick,
    output logic             irq
);
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction

    // Signal 3 and 4 under OR combining use inverted polarity
    function automatic logic is_inv(input logic or_mode, input logic [1:0] sel);
        return or_mode && sel[1];
    endfunction

    pse_pkg::pse_ctrl_t ctrl_r;
    logic [15:0]         clkdiv_r;
    logic [3:0]          last_r;
    logic [3:0]          seq_addr_r;
    logic [17:0]         seq_cnt_r;
    logic [7:0]          evt_addr_r;
    logic [7:0]          sig_care_r;
    logic [7:0]          sig_val_r;
    logic [3:0]          irq_stat_r;
    logic [3:0]          irq_en_r;
    pse_pkg::pse_line_t  lines [pse_pkg::NUM_LINES];

    logic        wr_req;
    logic        rd_req;
    logic [31:0] rd_nxt;
    logic [31:0] sig_word;

    assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign sig_word = lane_merge({16'h0000, sig_val_r, sig_care_r}, wb_dat_i, wb_sel_i);

    // Bus: one-cycle ack, data registered with it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= rd_req ? rd_nxt : 32'h0000_0000;
        end
    end

    // Control and configuration registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r     <= '0;
            clkdiv_r   <= pse_pkg::CLKDIV_RST;
            last_r     <= pse_pkg::LASTLINE_RST;
            seq_addr_r <= 4'h0;
            seq_cnt_r  <= 18'h0_0000;
            evt_addr_r <= 8'h00;
            sig_care_r <= 8'h00;
            sig_val_r  <= 8'h00;
            irq_en_r   <= 4'h0;
        end else if (wr_req) begin
            unique case (wb_adr_i)
                pse_pkg::OFS_CTRL:     ctrl_r     <= pse_pkg::pse_ctrl_t'(lane_merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
                pse_pkg::OFS_CLKDIV:   clkdiv_r   <= 16'(lane_merge({16'h0000, clkdiv_r}, wb_dat_i, wb_sel_i));
                pse_pkg::OFS_LASTLINE: last_r     <= 4'(lane_merge({28'h000_0000, last_r}, wb_dat_i, wb_sel_i));
                pse_pkg::OFS_SEQADDR:  seq_addr_r <= 4'(lane_merge({28'h000_0000, seq_addr_r}, wb_dat_i, wb_sel_i));
                pse_pkg::OFS_SEQCNT:   seq_cnt_r  <= 18'(lane_merge({14'h0000, seq_cnt_r}, wb_dat_i, wb_sel_i));
                pse_pkg::OFS_EVTADDR:  evt_addr_r <= 8'(lane_merge({24'h00_0000, evt_addr_r}, wb_dat_i, wb_sel_i));
                pse_pkg::OFS_SIGTERM: begin
                    sig_care_r <= sig_word[7:0];
                    sig_val_r  <= sig_word[15:8];
                end
                pse_pkg::OFS_IRQEN:    irq_en_r   <= 4'(lane_merge({28'h000_0000, irq_en_r}, wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
    end

    // Sequence table: an event word write commits the staged count word into the line
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < pse_pkg::NUM_LINES; i++) begin
                lines[i] <= '0;
            end
        end else if (wr_req && wb_adr_i == pse_pkg::OFS_SEQEVT) begin
            lines[seq_addr_r] <= pse_pkg::pse_line_t'({seq_cnt_r[15:0], seq_cnt_r[16], seq_cnt_r[17],
                                                       wb_dat_i[15:0]}); // R11
        end
    end

    // Input conditioning
    logic [7:0] own_ev;
    logic [7:0] lead_ev;
    logic [3:0] bp_in;
    logic [2:0] eclk_r;

    pse_cond #(.W(8)) u_own_cond (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .filt_en (ctrl_r.filt_en),
        .din     (ev_in),
        .dout    (own_ev)
    );
    pse_cond #(.W(8)) u_lead_cond (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .filt_en (ctrl_r.filt_en),
        .din     (lead_ev_in),
        .dout    (lead_ev)
    );
    pse_cond #(.W(4)) u_bp_cond (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .filt_en (1'b0),
        .din     (bp_sig_in),
        .dout    (bp_in)
    );

    // Pattern clock: internal divider or rising edge of the external clock pin
    logic [15:0] div_cnt_r;
    logic        tick;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            eclk_r    <= 3'b000;
            div_cnt_r <= 16'h0000;
        end else begin
            eclk_r    <= {eclk_r[1:0], ext_clk_in};
            div_cnt_r <= (div_cnt_r >= clkdiv_r) ? 16'h0000 : div_cnt_r + 16'h0001;
        end
    end

    assign tick = ctrl_r.run && (ctrl_r.clk_ext ? (eclk_r[1] && !eclk_r[2]) : (div_cnt_r >= clkdiv_r));

    // Event matching
    logic [7:0] seq_src;
    logic       sig_true;
    logic [7:0] def_seq;
    logic [7:0] def_own;
    logic       lut_wr;

    assign seq_src  = (ctrl_r.merge_en && !ctrl_r.leftmost) ? lead_ev : own_ev; // R06
    // Definition bits follow the wire level: 1 is true under AND, 0 is true under inverted OR
    assign sig_true = bp_in[ctrl_r.sig_in_sel]; // R04 R08 R09
    assign lut_wr   = wr_req && wb_adr_i == pse_pkg::OFS_EVTLUT;

    pse_match u_seq_match (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .wr_en    (lut_wr),
        .wr_addr  (evt_addr_r),
        .wr_data  (wb_dat_i[7:0]),
        .ev       (seq_src),
        .sig_true (sig_true),
        .sig_care (sig_care_r),
        .sig_val  (sig_val_r),
        .def_true (def_seq)
    );
    pse_match u_own_match (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .wr_en    (lut_wr),
        .wr_addr  (evt_addr_r),
        .wr_data  (wb_dat_i[7:0]),
        .ev       (own_ev), // R07
        .sig_true (sig_true),
        .sig_care (sig_care_r),
        .sig_val  (sig_val_r),
        .def_true (def_own)
    );

    // Edge capture between pattern ticks; a new rise in the tick cycle wins over the clear
    logic [7:0] def_d_r;
    logic [7:0] rise_r;
    logic [7:0] rise_now;

    assign rise_now = def_seq & ~def_d_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            def_d_r <= 8'h00;
            rise_r  <= 8'h00;
        end else begin
            def_d_r <= def_seq;
            rise_r  <= rise_now | (tick ? 8'h00 : rise_r); // R12
        end
    end

    // Sequencer
    pse_pkg::pse_line_t cur;
    logic [3:0]  pc_r;
    logic [15:0] cnt_r;
    logic [3:0]  nxt_pc;
    logic        adv_hit;
    logic        jmp_hit;
    logic        inh_hit;
    logic        wrap;

    assign cur     = lines[pc_r];
    assign nxt_pc  = (pc_r == last_r) ? 4'h0 : pc_r + 4'h1;
    assign adv_hit = cur.adv.en && (ctrl_r.adv_edge ? (rise_r[cur.adv.def] | rise_now[cur.adv.def])
                                                    : def_seq[cur.adv.def]); // R02 R12
    assign jmp_hit = cur.jmp.en && (ctrl_r.jmp_edge ? (rise_r[cur.jmp.def] | rise_now[cur.jmp.def])
                                                    : def_seq[cur.jmp.def]); // R02 R12
    assign inh_hit = ctrl_r.run && cur.inh.en && def_own[cur.inh.def]; // R02 R07
    assign wrap    = tick && !jmp_hit && (adv_hit || (!cur.inf && cnt_r == 16'h0000)) && pc_r == last_r;

    // Jump beats advance beats repeat expiry; an infinite line leaves only on an event
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_r  <= 4'h0;
            cnt_r <= 16'h0000;
        end else if (!ctrl_r.run) begin
            pc_r  <= 4'h0;
            cnt_r <= lines[0].rpt;
        end else if (tick) begin
            if (jmp_hit) begin
                pc_r  <= cur.tgt; // R02
                cnt_r <= lines[cur.tgt].rpt;
            end else if (adv_hit || (!cur.inf && cnt_r == 16'h0000)) begin
                pc_r  <= nxt_pc; // R02 R11
                cnt_r <= lines[nxt_pc].rpt;
            end else if (!cur.inf) begin
                cnt_r <= cnt_r - 16'h0001; // R11
            end
        end
    end

    // Outputs: backplane drive follows the executing line
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bp_sig_out  <= 4'h0;
            bp_sig_oe   <= 4'h0;
            pat_inhibit <= 1'b0;
            seq_line    <= 4'h0;
            pat_tick    <= 1'b0;
        end else begin
            for (int s = 0; s < pse_pkg::NUM_SIG; s++) begin
                bp_sig_oe[s]  <= ctrl_r.drive_en && ctrl_r.sig_out_sel == 2'(s); // R05 R10
                bp_sig_out[s] <= (ctrl_r.sig_out_sel == 2'(s)) &&
                                 (cur.lvl ^ is_inv(ctrl_r.or_mode, ctrl_r.sig_out_sel)); // R05 R08 R09
            end
            pat_inhibit <= inh_hit; // R02
            seq_line    <= pc_r;
            pat_tick    <= tick;
        end
    end

    // Interrupts: set wins over clear
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign irq_set = {wrap, inh_hit && !pat_inhibit, tick && !jmp_hit && adv_hit, tick && jmp_hit};
    assign irq_clr = (wr_req && wb_adr_i == pse_pkg::OFS_IRQCLR) ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_r <= 4'h0;
            irq       <= 1'b0;
        end else begin
            irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
            irq       <= |(irq_stat_r & irq_en_r);
        end
    end

    // Read mux
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (wb_adr_i)
            pse_pkg::OFS_CTRL:     rd_nxt = 32'(ctrl_r);
            pse_pkg::OFS_CLKDIV:   rd_nxt = {16'h0000, clkdiv_r};
            pse_pkg::OFS_LASTLINE: rd_nxt = {28'h000_0000, last_r};
            pse_pkg::OFS_SEQADDR:  rd_nxt = {28'h000_0000, seq_addr_r};
            pse_pkg::OFS_SEQCNT:   rd_nxt = {14'h0000, seq_cnt_r};
            pse_pkg::OFS_EVTADDR:  rd_nxt = {24'h00_0000, evt_addr_r};
            pse_pkg::OFS_SIGTERM:  rd_nxt = {16'h0000, sig_val_r, sig_care_r};
            pse_pkg::OFS_STATE:    rd_nxt = {8'h00, def_own, def_seq, 2'b00, bp_sig_out[ctrl_r.sig_out_sel],
                                             pat_inhibit, pc_r};
            pse_pkg::OFS_IRQSTAT:  rd_nxt = {28'h000_0000, irq_stat_r};
            pse_pkg::OFS_IRQEN:    rd_nxt = {28'h000_0000, irq_en_r};
            default:               rd_nxt = 32'h0000_0000;
        endcase
    end

    // Checks
    a_ack_single: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
    a_ack_latency: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack not given one cycle after request");
    a_merge_source: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
        (ctrl_r.merge_en && !ctrl_r.leftmost) |-> seq_src == lead_ev) else $error("merged module not on lead events");
    a_inhibit_own: assert property (@(posedge sys_clk) disable iff (!arst_n) // R07
        ##1 pat_inhibit == $past(ctrl_r.run && cur.inh.en && def_own[cur.inh.def])) else $error("inhibit wrong");
    a_jump_target: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
        (tick && jmp_hit) |=> pc_r == $past(cur.tgt)) else $error("jump did not reach target");
    a_advance_step: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
        (tick && !jmp_hit && adv_hit) |=> pc_r == $past(nxt_pc)) else $error("advance did not step");
    a_repeat_count: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
        (tick && !jmp_hit && !adv_hit && !cur.inf && cnt_r != 16'h0000)
        |=> (cnt_r == $past(cnt_r) - 16'h0001) && $stable(pc_r)) else $error("repeat count not decremented");
    a_infinite_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
        (ctrl_r.run && tick && cur.inf && !jmp_hit && !adv_hit) |=> $stable(pc_r)) else $error("infinite line left");
    a_drive_one: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
        $onehot0(bp_sig_oe)) else $error("more than one backplane line driven");
    a_drive_level: assert property (@(posedge sys_clk) disable iff (!arst_n) // R09
        ##1 bp_sig_out[$past(ctrl_r.sig_out_sel)] ==
            ($past(cur.lvl) ^ ($past(ctrl_r.or_mode) && $past(ctrl_r.sig_out_sel[1])))) else $error("level wrong");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 irq == $past(|(irq_stat_r & irq_en_r))) else $error("interrupt level wrong");
    a_stat_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
        irq_set[pse_pkg::IRQ_JUMP] |=> irq_stat_r[pse_pkg::IRQ_JUMP]) else $error("jump status lost");
endmodule // pse_top

/* verilog/pse_pkg.sv */
// Package holding constants, register map and carrier types of the sequencer event logic
// Overview of operation
// R01: Eight event definitions, each the OR of up to 256 input patterns.
// R02: A recognised event can advance, jump, or inhibit the pattern outputs.
// R03: Eight external event lines, two per probe, are sampled for matching.
// R04: One selectable backplane signal joins event definitions as an extra term.
// R05: One selected backplane line is driven at the level of the current line.
// R06: In a merge, advance and jump use the leftmost module's event inputs.
// R07: In a merge, inhibit always uses this module's own event inputs.
// R08: AND combining: high means true, definition bit 1 matches true.
// R09: OR combining on signal 3 or 4 inverts: low means true.
// R10: System-wide, only one module may drive signal 1, one signal 2.
// R11: Repeat count per line is 1 to 65536 or infinite until redirected.
// R12: Advance and jump are edge or level; optional filter drops short pulses.
package pse_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CLKDIV   = 8'h04;
    localparam logic [7:0] OFS_LASTLINE = 8'h08;
    localparam logic [7:0] OFS_SEQADDR  = 8'h0C;
    localparam logic [7:0] OFS_SEQCNT   = 8'h10;
    localparam logic [7:0] OFS_SEQEVT   = 8'h14;
    localparam logic [7:0] OFS_EVTADDR  = 8'h18;
    localparam logic [7:0] OFS_EVTLUT   = 8'h1C;
    localparam logic [7:0] OFS_SIGTERM  = 8'h20;
    localparam logic [7:0] OFS_STATE    = 8'h24;
    localparam logic [7:0] OFS_IRQSTAT  = 8'h28;
    localparam logic [7:0] OFS_IRQEN    = 8'h2C;
    localparam logic [7:0] OFS_IRQCLR   = 8'h30;

    // Sizes
    localparam int NUM_EV    = 8;
    localparam int NUM_DEF   = 8;
    localparam int NUM_PAT   = 256;
    localparam int NUM_SIG   = 4;
    localparam int NUM_LINES = 16;
    localparam int NUM_IRQ   = 4;

    // Interrupt bit positions
    localparam int IRQ_JUMP = 0;
    localparam int IRQ_ADV  = 1;
    localparam int IRQ_INH  = 2;
    localparam int IRQ_WRAP = 3;

    // Reset values
    localparam logic [15:0] CLKDIV_RST   = 16'h0000;
    localparam logic [3:0]  LASTLINE_RST = 4'h0;

    // Timing: clock rate and event filter width
    localparam int CLK_MHZ  = 10;
    localparam int FILT_NS  = 50;
    localparam int FILT_RAW = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;

    typedef struct packed {
        logic [1:0] sig_out_sel;
        logic [1:0] sig_in_sel;
        logic       drive_en;
        logic       or_mode;
        logic       jmp_edge;
        logic       adv_edge;
        logic       filt_en;
        logic       clk_ext;
        logic       leftmost;
        logic       merge_en;
        logic       run;
    } pse_ctrl_t;

    typedef struct packed {
        logic       en;
        logic [2:0] def;
    } pse_evsel_t;

    typedef struct packed {
        logic [15:0] rpt;
        logic        inf;
        logic        lvl;
        pse_evsel_t  adv;
        pse_evsel_t  jmp;
        logic [3:0]  tgt;
        pse_evsel_t  inh;
    } pse_line_t;

endpackage

/* verilog/pse_cond.sv */
// Input conditioner: two-stage synchroniser followed by an optional pulse-width filter
`timescale 1ns/1ps
module pse_cond #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    // Control
    input  wire logic         filt_en,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    // Output moves only after the input held its new value for FILT_CYC cycles
    genvar g;
    for (g = 0; g < W; g++) begin : g_filt
        logic [3:0] cnt_r;
        always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
                cnt_r   <= 4'h0;
                dout[g] <= 1'b0;
            end else if (!filt_en || sync_r[g] == dout[g]) begin
                cnt_r   <= 4'h0;
                dout[g] <= sync_r[g];
            end else if (cnt_r == 4'(pse_pkg::FILT_CYC - 1)) begin // R12
                cnt_r   <= 4'h0;
                dout[g] <= sync_r[g];
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule // pse_cond

/* verilog/pse_match.sv */
// Pattern matcher: 256-entry lookup of event inputs to definition bits, plus backplane term
`timescale 1ns/1ps
module pse_match (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Table write
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Match inputs
    input  wire logic [7:0] ev,
    input  wire logic       sig_true,
    input  wire logic [7:0] sig_care,
    input  wire logic [7:0] sig_val,
    // Result
    output logic      [7:0] def_true
);
    logic [7:0]   lut [pse_pkg::NUM_PAT];
    logic [255:0] valid_r;
    logic [7:0]   hit;

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            lut[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_r <= '0;
        end else if (wr_en) begin
            valid_r[wr_addr] <= 1'b1;
        end
    end

    // Each input pattern marks the definitions it belongs to; any marked pattern makes it true
    assign hit = valid_r[ev] ? lut[ev] : 8'h00; // R01 R03

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            def_true <= 8'h00;
        end else begin
            def_true <= hit & (~sig_care | ~(sig_val ^ {8{sig_true}})); // R04 R08
        end
    end
endmodule // pse_match

/* test/pse_bp_model.sv */
// Backplane model: other modules sharing the four signal lines, pulled high where nobody drives
`timescale 1ns/1ps
module pse_bp_model (
    // Design side
    input  wire logic [3:0] bp_sig_out,
    input  wire logic [3:0] bp_sig_oe,
    // Other modules' drive
    input  wire logic [3:0] peer_oe,
    input  wire logic [3:0] peer_lvl,
    // Wire level seen by everyone
    output logic      [3:0] bp_sig_in
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (bp_sig_oe[i])
                bp_sig_in[i] = bp_sig_out[i];
            else if (peer_oe[i])
                bp_sig_in[i] = peer_lvl[i];
            else
                bp_sig_in[i] = 1'b1;
        end
    end
endmodule // pse_bp_model

/* test/pse_bench.sv */
// Testbench for the sequencer event logic
`timescale 1ns/1ps
module pattern_sequencer_event_logic_bench;
    logic        sys_clk = 0;
    logic        arst_n = 0;
    logic        wb_cyc_i = 0;
    logic        wb_stb_i = 0;
    logic        wb_we_i = 0;
    logic [7:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0;
    logic [31:0] wb_dat_o, q;
    logic        wb_ack_o, pat_inhibit, pat_tick, irq;
    logic [7:0]  ev_in = 0;
    logic [7:0]  lead_ev_in = 0;
    logic [3:0]  peer_oe = 0;
    logic [3:0]  peer_lvl = 0;
    logic        ext_clk_in = 0;
    logic [3:0]  bp_sig_in, bp_sig_out, bp_sig_oe, seq_line;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;

    always #50 sys_clk = ~sys_clk;

    pse_top pse_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ev_in(ev_in), .lead_ev_in(lead_ev_in), .ext_clk_in(ext_clk_in),
        .bp_sig_in(bp_sig_in), .bp_sig_out(bp_sig_out), .bp_sig_oe(bp_sig_oe), .pat_inhibit(pat_inhibit),
        .seq_line(seq_line), .pat_tick(pat_tick), .irq(irq));
    pse_bp_model pse_bp_model_inst (.bp_sig_out(bp_sig_out), .bp_sig_oe(bp_sig_oe), .peer_oe(peer_oe),
        .peer_lvl(peer_lvl), .bp_sig_in(bp_sig_in));

    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; waits for ack, then releases
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Program one sequence line: staged count word, then commit with event word
    task automatic line(input logic [3:0] a, input logic [31:0] cnt, input logic [31:0] evt);
        wb(1, pse_pkg::OFS_SEQADDR, {28'h0, a});
        wb(1, pse_pkg::OFS_SEQCNT, cnt);
        wb(1, pse_pkg::OFS_SEQEVT, evt);
    endtask

    task automatic t_regs;
        wb(0, pse_pkg::OFS_CTRL, 0);
        chk(q, 32'h0000_0000);
        wb(0, 8'h3C, 0);
        chk(q, 32'h0000_0000);
        wb(0, pse_pkg::OFS_IRQSTAT, 0);
        chk(q, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_drive;
        line(4'h0, 32'h0003_0000, 32'h0000_0000);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_0101);
        repeat (6) @(posedge sys_clk);
        chk({28'h0, bp_sig_oe}, 32'h0000_0001);
        chk({31'h0, bp_sig_out[0]}, 32'h0000_0001);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_1181);
        repeat (6) @(posedge sys_clk);
        chk({28'h0, bp_sig_oe}, 32'h0000_0004);
        chk({31'h0, bp_sig_out[2]}, 32'h0000_0000);
        wb(1, pse_pkg::OFS_CTRL, 0);
        $display("test drive done");
    endtask

    task automatic t_inhibit;
        wb(1, pse_pkg::OFS_EVTADDR, 32'h0000_0001);
        wb(1, pse_pkg::OFS_EVTLUT, 32'h0000_0001);
        line(4'h0, 32'h0001_0000, 32'h0000_0008);
        wb(1, pse_pkg::OFS_IRQEN, 32'h0000_0004);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_0001);
        ev_in <= 8'h01;
        for (int n = 0; n < 20 && pat_inhibit !== 1'b1; n++) @(posedge sys_clk);
        chk({31'h0, pat_inhibit}, 32'h0000_0001);
        wb(0, pse_pkg::OFS_IRQSTAT, 0);
        chk(q & 32'h0000_0004, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0001);
        ev_in <= 8'h00;
        repeat (8) @(posedge sys_clk);
        wb(1, pse_pkg::OFS_IRQCLR, 32'h0000_0004);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wb(1, pse_pkg::OFS_CTRL, 0);
        $display("test inhibit done");
    endtask

    task automatic t_merge_jump;
        wb(1, pse_pkg::OFS_EVTADDR, 32'h0000_0002);
        wb(1, pse_pkg::OFS_EVTLUT, 32'h0000_0002);
        wb(1, pse_pkg::OFS_LASTLINE, 32'h0000_0007);
        line(4'h0, 32'h0001_0000, 32'h0000_0950);
        line(4'h5, 32'h0001_0000, 32'h0000_0000);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_0003);
        ev_in <= 8'h02;
        repeat (12) @(posedge sys_clk);
        chk({28'h0, seq_line}, 32'h0000_0000);
        lead_ev_in <= 8'h02;
        for (int n = 0; n < 20 && seq_line !== 4'h5; n++) @(posedge sys_clk);
        chk({28'h0, seq_line}, 32'h0000_0005);
        ev_in <= 8'h00;
        lead_ev_in <= 8'h00;
        wb(1, pse_pkg::OFS_CTRL, 0);
        $display("test merge jump done");
    endtask

    // Signal 3 under OR: definition bit 0 matches only while the line is pulled low
    task automatic t_sig;
        wb(1, pse_pkg::OFS_EVTADDR, 32'h0000_0000);
        wb(1, pse_pkg::OFS_EVTLUT, 32'h0000_0004);
        wb(1, pse_pkg::OFS_SIGTERM, 32'h0000_0004);
        line(4'h0, 32'h0001_0000, 32'h0000_0A50);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_0481);
        repeat (12) @(posedge sys_clk);
        chk({28'h0, seq_line}, 32'h0000_0000);
        peer_oe <= 4'h4;
        for (int n = 0; n < 20 && seq_line !== 4'h5; n++) @(posedge sys_clk);
        chk({28'h0, seq_line}, 32'h0000_0005);
        peer_oe <= 4'h0;
        wb(1, pse_pkg::OFS_CTRL, 0);
        wb(1, pse_pkg::OFS_SIGTERM, 0);
        $display("test signal term done");
    endtask

    // Count field 4 means five pattern steps on line 0
    task automatic t_repeat;
        int n;
        n = 0;
        wb(1, pse_pkg::OFS_LASTLINE, 32'h0000_0001);
        line(4'h0, 32'h0000_0004, 32'h0000_0000);
        line(4'h1, 32'h0001_0000, 32'h0000_0000);
        wb(1, pse_pkg::OFS_CTRL, 32'h0000_0001);
        do begin
            @(posedge sys_clk);
            if (seq_line === 4'h0) n += pat_tick;
        end while (seq_line !== 4'h1 && n < 40);
        chk(n, 5);
        wb(1, pse_pkg::OFS_CTRL, 0);
        $display("test repeat done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_drive();
        t_inhibit();
        t_merge_jump();
        t_sig();
        t_repeat();
        final_report();
    end
endmodule // pattern_sequencer_event_logic_bench
